/* core/amt_regs.sv */
// mode-control, memory-test, chassis-number and synthetic-event registers of the charge digitiser
//
// Function
// [RULE1] set port ORs written ones into the mode register; reads return its contents
// [RULE2] clear port zeroes every mode bit written as one; value four clears flush
// [RULE3] ram test bit enables direct pattern writes into the output memory; default off
// [RULE4] converter halt bit blocks all conversion starts; default online
// [RULE5] flush bit drives a data reset of stored data, pointers, counter, integrators
// [RULE6] overflow filter drops overflowing conversions unless disabled by its bit
// [RULE7] zero filter stores only data at or above threshold unless its off bit is set
// [RULE8] synthetic select takes stored event data from the test fifo, not conversions
// [RULE9] slide enable runs dither, else constant drives dac; sub-off kills subtraction only
// [RULE10] scale bit picks suppression below threshold times 16 or times 2
// [RULE11] auto-advance bit lets pointer run itself; else only port writes advance it
// [RULE12] blank-event bit writes header and end-of-block word for empty events
// [RULE13] count-every-trigger bit counts all triggers, else accepted triggers only
// [RULE14] write-only port holds an 11-bit memory-test write address
// [RULE15] master keeps memory-test read address different from the write address
// [RULE16] upper and lower pattern halves latch; lower write commits 32 bits to memory
// [RULE17] master writes test mode, address, upper half, then lower half in order
// [RULE18] chassis number is read/write, set at init, embedded in output data words
// [RULE19] each test-event write pushes a 32-entry fifo; drained as one event in test mode
// [RULE20] each test word carries a 12-bit result and an overflow flag
// [RULE21] master writes test words in interleaved readout order, 0,16,1,17..15,31
// [RULE22] master writes exactly 32 test words; extras overwrite earlier ones
// [RULE23] increment-word port moves readout pointer one word, crossing end-of-block words
// [RULE24] increment-event port moves readout pointer to the next event's first word
// [RULE25] data reset is a level held while flush bit stays set until cleared
`timescale 1ns/10ps
module amt_regs
  import amt_pkg::*;
#(
  parameter int SYN_DEPTH = AMT_SYN_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire amt_req_type reg_req,
  output logic [AMT_REG_W-1:0] reg_rdata,
  output logic reg_rvalid,
  output amt_mode_type mode,
  output logic data_reset,
  input wire logic conv_start_req,
  output logic conv_start,
  input wire logic conv_valid,
  input wire amt_conv_type conv_in,
  input wire logic [AMT_THR_W-1:0] conv_threshold,
  output logic store_valid,
  output amt_conv_type store_word,
  input wire logic [AMT_DAC_W-1:0] dither_code,
  input wire logic [AMT_DAC_W-1:0] slide_constant,
  output logic [AMT_DAC_W-1:0] dac_code,
  output logic slide_sub_en,
  input wire logic trigger,
  input wire logic trigger_accepted,
  output logic event_count_inc,
  input wire logic event_end,
  input wire logic event_no_channel,
  output logic event_frame_wr,
  output logic ptr_auto_en,
  output logic ptr_next_word,
  output logic ptr_next_event,
  output logic [AMT_TADDR_W-1:0] memtest_addr,
  output logic memtest_wr,
  output logic [AMT_PATTERN_W-1:0] memtest_data,
  output logic [AMT_CHASSIS_W-1:0] chassis_num,
  output logic syn_valid,
  output amt_conv_type syn_word,
  input wire logic syn_ready
);

  amt_mode_type mode_ff;
  amt_mode_type nxt_mode;
  logic [AMT_REG_W-1:0] rdata_ff;
  logic rvalid_ff;
  logic data_reset_ff;
  logic conv_start_ff;
  logic store_valid_ff;
  amt_conv_type store_word_ff;
  logic [AMT_DAC_W-1:0] dac_ff;
  logic sub_en_ff;
  logic evcnt_inc_ff;
  logic frame_wr_ff;
  logic ptr_auto_ff;
  logic ptr_word_ff;
  logic ptr_event_ff;
  logic [AMT_TADDR_W-1:0] taddr_ff;
  logic [AMT_REG_W-1:0] pat_upper_ff;
  logic memtest_wr_ff;
  logic [AMT_PATTERN_W-1:0] memtest_data_ff;
  logic [AMT_TADDR_W-1:0] memtest_addr_ff;
  logic [AMT_CHASSIS_W-1:0] chassis_ff;
  logic [AMT_REG_W-1:0] syn_raw;
  logic wr_set;
  logic wr_clear;
  logic below_thr;
  logic [AMT_CONV_W:0] thr_scaled;
  logic [AMT_REG_W-1:0] wmask;

  assign wr_set = reg_req.wr && (reg_req.addr == AMT_OFS_MODE_SET);
  assign wr_clear = reg_req.wr && (reg_req.addr == AMT_OFS_MODE_CLEAR);
  // reserved bits are neither settable nor clearable, so they keep their zero
  assign wmask = reg_req.data & AMT_MODE_MASK;

  always_comb
  begin
    nxt_mode = mode_ff;
    if (wr_set)
    begin
      nxt_mode = amt_mode_type'(AMT_REG_W'(mode_ff) | wmask); // [RULE1]
    end
    else if (wr_clear)
    begin
      nxt_mode = amt_mode_type'(AMT_REG_W'(mode_ff) & ~wmask); // [RULE2]
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_ff <= amt_mode_type'(AMT_MODE_RESET);
    end
    else
    begin
      mode_ff <= nxt_mode;
    end
  end

  // read answer one cycle after the strobe; write-only ports read as zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= reg_req.rd;
      if (reg_req.rd)
      begin
        case (reg_req.addr)
          AMT_OFS_MODE_SET: rdata_ff <= AMT_REG_W'(mode_ff); // [RULE1]
          AMT_OFS_CHASSIS: rdata_ff <= {{(AMT_REG_W-AMT_CHASSIS_W){1'b0}}, chassis_ff}; // [RULE18]
          default: rdata_ff <= 16'h0000;
        endcase
      end
    end
  end

  // the flush stays a level, so everything downstream is held in reset until software clears it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_reset_ff <= 1'b0;
    end
    else
    begin
      data_reset_ff <= mode_ff.data_flush; // [RULE5] [RULE25]
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_start_ff <= 1'b0;
    end
    else
    begin
      conv_start_ff <= conv_start_req && !mode_ff.converter_halt && !mode_ff.data_flush; // [RULE4]
    end
  end

  // threshold of 8 bits scaled to the 12-bit result range
  always_comb
  begin
    if (mode_ff.threshold_scale_sel)
    begin
      thr_scaled = (AMT_CONV_W+1)'(conv_threshold) << AMT_THR_SHIFT_FINE; // [RULE10]
    end
    else
    begin
      thr_scaled = (AMT_CONV_W+1)'(conv_threshold) << AMT_THR_SHIFT_COARSE; // [RULE10]
    end
  end

  assign below_thr = ({1'b0, conv_in.value} < thr_scaled);

  // real conversions are not stored while synthetic events own the buffer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      store_valid_ff <= 1'b0;
      store_word_ff <= '0;
    end
    else
    begin
      store_valid_ff <= conv_valid
                        && !mode_ff.synthetic_event_sel // [RULE8]
                        && !mode_ff.data_flush
                        && (mode_ff.overflow_filter_off || !conv_in.overflow_flag) // [RULE6]
                        && (mode_ff.zero_filter_off || !below_thr); // [RULE7]
      if (conv_valid)
      begin
        store_word_ff <= conv_in;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dac_ff <= 8'h00;
      sub_en_ff <= 1'b0;
    end
    else
    begin
      dac_ff <= mode_ff.slide_en ? dither_code : slide_constant; // [RULE9]
      sub_en_ff <= mode_ff.slide_en && !mode_ff.slide_sub_off; // [RULE9]
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      evcnt_inc_ff <= 1'b0;
    end
    else
    begin
      evcnt_inc_ff <= trigger && (mode_ff.count_every_trigger || trigger_accepted); // [RULE13]
    end
  end

  // an event with accepted channels always frames; an empty one only when enabled
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_wr_ff <= 1'b0;
    end
    else
    begin
      frame_wr_ff <= event_end && (!event_no_channel || mode_ff.blank_event_en); // [RULE12]
    end
  end

  // manual pointer ports act in either mode; auto-advance only adds the automatic steps
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr_auto_ff <= 1'b0;
      ptr_word_ff <= 1'b0;
      ptr_event_ff <= 1'b0;
    end
    else
    begin
      ptr_auto_ff <= mode_ff.pointer_auto_advance; // [RULE11]
      ptr_word_ff <= reg_req.wr && (reg_req.addr == AMT_OFS_PTR_NEXT_WORD); // [RULE23]
      ptr_event_ff <= reg_req.wr && (reg_req.addr == AMT_OFS_PTR_NEXT_EVENT); // [RULE24]
    end
  end

  // memory-test write path; the upper half must be latched before the lower one commits
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      taddr_ff <= '0;
      pat_upper_ff <= 16'h0000;
    end
    else
    begin
      if (reg_req.wr && (reg_req.addr == AMT_OFS_MEMTEST_WADDR))
      begin
        taddr_ff <= reg_req.data[AMT_TADDR_W-1:0]; // [RULE14]
      end
      if (reg_req.wr && (reg_req.addr == AMT_OFS_PATTERN_UPPER))
      begin
        pat_upper_ff <= reg_req.data; // [RULE16]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      memtest_wr_ff <= 1'b0;
      memtest_addr_ff <= '0;
      memtest_data_ff <= '0;
    end
    else
    begin
      memtest_wr_ff <= 1'b0;
      if (reg_req.wr && (reg_req.addr == AMT_OFS_PATTERN_LOWER))
      begin
        memtest_wr_ff <= mode_ff.ram_test_sel; // [RULE3]
        memtest_addr_ff <= taddr_ff; // [RULE14]
        memtest_data_ff <= {pat_upper_ff, reg_req.data}; // [RULE16]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chassis_ff <= 8'h00;
    end
    else if (reg_req.wr && (reg_req.addr == AMT_OFS_CHASSIS))
    begin
      chassis_ff <= reg_req.data[AMT_CHASSIS_W-1:0]; // [RULE18]
    end
  end

  // fifo is emptied by the flush bit itself, a cycle ahead of the data reset, since it counts as stored data
  amt_test_fifo #(
    .W(AMT_REG_W),
    .DEPTH(SYN_DEPTH)
  ) u_syn_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .clear(mode_ff.data_flush),
    .push(reg_req.wr && (reg_req.addr == AMT_OFS_SYN_PUSH)), // [RULE19]
    .push_data(reg_req.data),
    .drain_en(mode_ff.synthetic_event_sel), // [RULE8] [RULE19]
    .out_ready(syn_ready),
    .out_valid(syn_valid),
    .out_data(syn_raw),
    .count()
  );

  assign syn_word = amt_conv_type'(syn_raw[AMT_OVF_BIT:0]); // [RULE20]

  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign mode = mode_ff;
  assign data_reset = data_reset_ff;
  assign conv_start = conv_start_ff;
  assign store_valid = store_valid_ff;
  assign store_word = store_word_ff;
  assign dac_code = dac_ff;
  assign slide_sub_en = sub_en_ff;
  assign event_count_inc = evcnt_inc_ff;
  assign event_frame_wr = frame_wr_ff;
  assign ptr_auto_en = ptr_auto_ff;
  assign ptr_next_word = ptr_word_ff;
  assign ptr_next_event = ptr_event_ff;
  assign memtest_addr = memtest_addr_ff;
  assign memtest_wr = memtest_wr_ff;
  assign memtest_data = memtest_data_ff;
  assign chassis_num = chassis_ff;

endmodule

/* core/amt_pkg.sv */
// shared constants, register map and carrier types for the acquisition mode and test registers
package amt_pkg;

  // register offsets on the module's register port
  localparam logic [15:0] AMT_OFS_PTR_NEXT_EVENT = 16'h1028;
  localparam logic [15:0] AMT_OFS_PTR_NEXT_WORD = 16'h102a;
  localparam logic [15:0] AMT_OFS_MODE_SET = 16'h1032;
  localparam logic [15:0] AMT_OFS_MODE_CLEAR = 16'h1034;
  localparam logic [15:0] AMT_OFS_MEMTEST_WADDR = 16'h1036;
  localparam logic [15:0] AMT_OFS_PATTERN_UPPER = 16'h1038;
  localparam logic [15:0] AMT_OFS_PATTERN_LOWER = 16'h103a;
  localparam logic [15:0] AMT_OFS_CHASSIS = 16'h103c;
  localparam logic [15:0] AMT_OFS_SYN_PUSH = 16'h103e;

  // mode register: implemented bits and reset value
  localparam logic [15:0] AMT_MODE_MASK = 16'h79df;
  localparam logic [15:0] AMT_MODE_RESET = 16'h4880;

  // field widths and positions
  localparam int AMT_REG_W = 16;
  localparam int AMT_TADDR_W = 11;
  localparam int AMT_CHASSIS_W = 8;
  localparam int AMT_CONV_W = 12;
  localparam int AMT_OVF_BIT = 12;
  localparam int AMT_THR_W = 8;
  localparam int AMT_DAC_W = 8;
  localparam int AMT_PATTERN_W = 32;
  localparam int AMT_SYN_DEPTH = 32;

  // threshold multipliers as left shifts: x2 and x16
  localparam int AMT_THR_SHIFT_FINE = 1;
  localparam int AMT_THR_SHIFT_COARSE = 4;

  typedef struct packed {
    logic rsv15;
    logic count_every_trigger;
    logic slide_sub_off;
    logic blank_event_en;
    logic pointer_auto_advance;
    logic [1:0] rsv10_9;
    logic threshold_scale_sel;
    logic slide_en;
    logic synthetic_event_sel;
    logic rsv5;
    logic zero_filter_off;
    logic overflow_filter_off;
    logic data_flush;
    logic converter_halt;
    logic ram_test_sel;
  } amt_mode_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] data;
  } amt_req_type;

  typedef struct packed {
    logic overflow_flag;
    logic [AMT_CONV_W-1:0] value;
  } amt_conv_type;

endpackage

/* core/amt_test_fifo.sv */
// synthetic-event fifo: pushes overwrite the oldest entry when full, registered drain port
`timescale 1ns/10ps
module amt_test_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic push,
  input wire logic [W-1:0] push_data,
  input wire logic drain_en,
  input wire logic out_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] cnt_ff;
  logic out_valid_ff;
  logic [W-1:0] out_data_ff;
  logic full;
  logic pop;

  assign full = (cnt_ff == FULL_CNT);
  assign pop = drain_en && (cnt_ff != '0) && (!out_valid_ff || out_ready);
  assign out_valid = out_valid_ff;
  assign out_data = out_data_ff;
  assign count = cnt_ff;

  always_ff @(posedge clk)
  begin
    if (push && !clear)
    begin
      mem[wr_ptr_ff] <= push_data;
    end
  end

  // a push into a full fifo drops the oldest word, so extra writes overwrite earlier ones
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end
    else if (clear)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop || (push && full))
      begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !full && !pop)
      begin
        cnt_ff <= cnt_ff + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_valid_ff <= 1'b0;
      out_data_ff <= '0;
    end
    else if (clear)
    begin
      out_valid_ff <= 1'b0;
    end
    else if (pop)
    begin
      out_valid_ff <= 1'b1;
      out_data_ff <= mem[rd_ptr_ff];
    end
    else if (out_ready)
    begin
      out_valid_ff <= 1'b0;
    end
  end

endmodule

/* testbench/amt_bus_master.sv */
// backplane bus master model issuing register reads and writes
`timescale 1ns/10ps
module amt_bus_master
  import amt_pkg::*;
(
  input wire logic clk,
  output amt_req_type reg_req,
  input wire logic [AMT_REG_W-1:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial reg_req = '0;
  task automatic xfer(input logic w, input logic [15:0] a, d, output logic [15:0] q);
    @(negedge clk);
    reg_req = {w, ~w, a, d};
    @(negedge clk);
    // released lines carry the inverse so a stale value never looks live
    reg_req = {2'b00, ~a, ~d};
    q = reg_rdata;
  endtask
  task automatic wr(input logic [15:0] a, d);
    logic [15:0] q;
    xfer(1'b1, a, d, q);
  endtask
  // only the write address is programmed, so no read address can collide with it
  task automatic memtest(input logic [15:0] a, input logic [31:0] p);
    wr(AMT_OFS_MEMTEST_WADDR, a);
    wr(AMT_OFS_PATTERN_UPPER, p[31:16]);
    wr(AMT_OFS_PATTERN_LOWER, p[15:0]);
  endtask
  task automatic syn_event(input logic [15:0] base);
    for (int i = 0; i < 32; i++)
      wr(AMT_OFS_SYN_PUSH, base ^ 16'((i % 2) * 16 + i / 2));
  endtask
endmodule

/* testbench/amt_regs_monitor.sv */
// concurrent checks on the mode, memory-test and chassis register ports
`timescale 1ns/10ps
module amt_regs_monitor
  import amt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire amt_req_type reg_req,
  input wire logic [AMT_REG_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire amt_mode_type mode,
  input wire logic data_reset,
  input wire logic conv_start_req,
  input wire logic conv_start,
  input wire logic conv_valid,
  input wire logic store_valid,
  input wire logic trigger,
  input wire logic trigger_accepted,
  input wire logic event_count_inc,
  input wire logic ptr_next_word,
  input wire logic ptr_next_event,
  input wire logic [AMT_TADDR_W-1:0] memtest_addr,
  input wire logic memtest_wr,
  input wire logic [AMT_PATTERN_W-1:0] memtest_data,
  input wire logic [AMT_CHASSIS_W-1:0] chassis_num
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  function automatic logic wa(amt_req_type r, logic [15:0] a);
    return r.wr && r.addr == a;
  endfunction
  sequence s_upper;
    wa(reg_req, AMT_OFS_PATTERN_UPPER);
  endsequence
  sequence s_commit;
    wa(reg_req, AMT_OFS_PATTERN_LOWER) && mode.ram_test_sel;
  endsequence
  AST_SET: assert property (wa(reg_req, AMT_OFS_MODE_SET)
    |=> mode == ($past(mode) | ($past(reg_req.data) & AMT_MODE_MASK))) else $error("mode set wrong");
  AST_CLEAR: assert property (wa(reg_req, AMT_OFS_MODE_CLEAR)
    |=> mode == ($past(mode) & ~$past(reg_req.data))) else $error("mode clear wrong");
  AST_READ: assert property (reg_req.rd && reg_req.addr == AMT_OFS_MODE_SET
    |=> reg_rvalid && reg_rdata == $past(mode)) else $error("mode read wrong");
  AST_FLUSH: assert property (1 |=> data_reset == $past(mode.data_flush))
    else $error("data reset does not follow flush");
  AST_HALT: assert property (1 |=> conv_start ==
    $past(conv_start_req && !mode.converter_halt && !mode.data_flush)) else $error("conversion start wrong");
  AST_COUNT: assert property (1 |=> event_count_inc ==
    $past(trigger && (mode.count_every_trigger || trigger_accepted))) else $error("event count wrong");
  AST_STORE: assert property (store_valid |-> $past(conv_valid && !mode.synthetic_event_sel))
    else $error("store without real conversion");
  AST_COMMIT: assert property (s_commit |=> memtest_wr && memtest_data[15:0] == $past(reg_req.data))
    else $error("pattern commit wrong");
  AST_UPPER: assert property (s_upper ##2 s_commit |=> memtest_data[31:16] == $past(reg_req.data, 3))
    else $error("upper half lost");
  AST_NOTEST: assert property (wa(reg_req, AMT_OFS_PATTERN_LOWER) && !mode.ram_test_sel |=> !memtest_wr)
    else $error("memory written outside test mode");
  // the address only shows on the output once the lower half is written, in any mode; checked here in ram test mode
  AST_TADDR: assert property (wa(reg_req, AMT_OFS_MEMTEST_WADDR) ##2 s_upper ##2 s_commit
    |=> memtest_addr == $past(reg_req.data[10:0], 5)) else $error("test address wrong");
  AST_CHASSIS: assert property (wa(reg_req, AMT_OFS_CHASSIS)
    |=> chassis_num == $past(reg_req.data[7:0])) else $error("chassis number wrong");
  AST_WORD: assert property (wa(reg_req, AMT_OFS_PTR_NEXT_WORD) |=> ptr_next_word)
    else $error("word advance missing");
  AST_EVENT: assert property (wa(reg_req, AMT_OFS_PTR_NEXT_EVENT) |=> ptr_next_event)
    else $error("event advance missing");
endmodule
bind amt_regs amt_regs_monitor amt_regs_monitor_i (.clk, .rst_n, .reg_req, .reg_rdata, .reg_rvalid, .mode,
  .data_reset, .conv_start_req, .conv_start, .conv_valid, .store_valid, .trigger, .trigger_accepted,
  .event_count_inc, .ptr_next_word, .ptr_next_event, .memtest_addr, .memtest_wr, .memtest_data, .chassis_num);

/* testbench/amt_regs_tb_top.sv */
// self-checking testbench for the acquisition mode and test registers
`timescale 1ns/10ps
module amt_regs_tb_top
  import amt_pkg::*;
;
  logic clk, rst_n, conv_start_req, conv_start, conv_valid, store_valid, slide_sub_en, trigger, trigger_accepted;
  logic event_count_inc, event_end, event_no_channel, event_frame_wr, memtest_wr, syn_valid, syn_ready;
  logic reg_rvalid, data_reset, ptr_auto_en;
  logic [15:0] reg_rdata;
  logic [7:0] conv_threshold, dither_code, slide_constant, dac_code, chassis_num;
  logic [10:0] memtest_addr;
  logic [31:0] memtest_data;
  amt_req_type reg_req;
  amt_mode_type mode;
  amt_conv_type conv_in, syn_word, store_word;
  amt_conv_type sy_got [64];
  int fails, tests_run, mt_n, sy_n, cycles;

  amt_regs amt_regs_i (.clk, .rst_n, .reg_req, .reg_rdata, .reg_rvalid, .mode, .data_reset, .conv_start_req,
    .conv_start, .conv_valid, .conv_in, .conv_threshold, .store_valid, .store_word, .dither_code,
    .slide_constant, .dac_code, .slide_sub_en, .trigger, .trigger_accepted, .event_count_inc, .event_end,
    .event_no_channel, .event_frame_wr, .ptr_auto_en, .ptr_next_word(), .ptr_next_event(), .memtest_addr,
    .memtest_wr, .memtest_data, .chassis_num, .syn_valid, .syn_word, .syn_ready);
  amt_bus_master amt_bus_master_i (.clk, .reg_req, .reg_rdata, .reg_rvalid);

  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (memtest_wr)
      mt_n++;
    if (syn_valid && syn_ready && sy_n < 64)
    begin
      sy_got[sy_n] = syn_word;
      sy_n++;
    end
    // generous ceiling: the whole sequence needs well under a thousand cycles
    if (cycles == 5000)
    begin
      fails++;
      results;
    end
  end

  task chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [15:0] a, d);
    amt_bus_master_i.wr(a, d);
  endtask
  task rd_chk(input logic [15:0] a, exp);
    logic [15:0] q;
    amt_bus_master_i.xfer(1'b0, a, 16'h0000, q);
    chk(q, exp);
  endtask
  task setm(input logic [15:0] m);
    wr(AMT_OFS_MODE_CLEAR, 16'hffff);
    wr(AMT_OFS_MODE_SET, m);
  endtask
  task step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task t_regs;
    rd_chk(AMT_OFS_MODE_SET, AMT_MODE_RESET);
    chk(ptr_auto_en, 1'b1);
    rd_chk(AMT_OFS_SYN_PUSH, 16'h0000);
    rd_chk(16'h1030, 16'h0000);
    wr(AMT_OFS_MODE_SET, 16'hffff);
    rd_chk(AMT_OFS_MODE_SET, AMT_MODE_MASK);
    wr(AMT_OFS_MODE_CLEAR, 16'h0004);
    rd_chk(AMT_OFS_MODE_SET, AMT_MODE_MASK & 16'hfffb);
    wr(AMT_OFS_MODE_CLEAR, 16'hffff);
    rd_chk(AMT_OFS_MODE_SET, 16'h0000);
    chk(ptr_auto_en, 1'b0);
    wr(AMT_OFS_CHASSIS, 16'h12a5);
    rd_chk(AMT_OFS_CHASSIS, 16'h00a5);
    // auto-advance is off here, so only these port writes move the pointer
    wr(AMT_OFS_PTR_NEXT_WORD, 16'h0000);
    wr(AMT_OFS_PTR_NEXT_EVENT, 16'h0000);
  endtask

  task conv(input logic [15:0] m, input logic [12:0] v, input logic es, ec);
    setm(m);
    @(negedge clk);
    conv_valid = 1;
    conv_start_req = 1;
    conv_in = v;
    @(negedge clk);
    conv_valid = 0;
    conv_start_req = 0;
    chk(store_valid, es);
    chk(conv_start, ec);
    chk(store_word, v);
  endtask

  task evt(input logic [15:0] m, input logic acc, ec, ef);
    setm(m);
    @(negedge clk);
    {trigger, trigger_accepted, event_end, event_no_channel} = {1'b1, acc, 2'b11};
    @(negedge clk);
    {trigger, trigger_accepted, event_end, event_no_channel} = 4'h0;
    chk(event_count_inc, ec);
    chk(event_frame_wr, ef);
  endtask

  task t_slide;
    setm(16'h0080);
    step(2);
    chk(dac_code, 8'h5a);
    chk(slide_sub_en, 1'b1);
    wr(AMT_OFS_MODE_SET, 16'h2000);
    step(2);
    chk(slide_sub_en, 1'b0);
    chk(dac_code, 8'h5a);
    wr(AMT_OFS_MODE_CLEAR, 16'h0080);
    step(2);
    chk(dac_code, 8'ha5);
  endtask

  task t_flush;
    setm(16'h0004);
    step(2);
    chk(data_reset, 1'b1);
    step(6);
    chk(data_reset, 1'b1);
    wr(AMT_OFS_MODE_CLEAR, 16'h0004);
    step(2);
    chk(data_reset, 1'b0);
  endtask

  task t_memtest;
    setm(16'h0000);
    amt_bus_master_i.memtest(16'h0005, 32'habcd1234);
    step(2);
    chk(mt_n, 0);
    wr(AMT_OFS_MODE_SET, 16'h0001);
    amt_bus_master_i.memtest(16'hfffd, 32'h89ab4321);
    step(2);
    chk(mt_n, 1);
    chk(memtest_addr, 11'h7fd);
    chk(memtest_data, 32'h89ab4321);
  endtask

  // the far side stalls first, so the head word must be held until taken
  task t_syn;
    setm(16'h0000);
    amt_bus_master_i.syn_event(16'hf9c0);
    wr(AMT_OFS_MODE_SET, 16'h0040);
    step(4);
    chk(syn_valid, 1'b1);
    chk(syn_word, 13'h19c0);
    syn_ready = 1;
    step(40);
    chk(sy_n, 32);
    for (int i = 0; i < 32; i++)
      chk(sy_got[i], 13'(16'hf9c0 ^ 16'((i % 2) * 16 + i / 2)));
  endtask

  task results;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    {rst_n, conv_start_req, conv_valid, trigger, trigger_accepted, event_end, event_no_channel, syn_ready} = 8'h00;
    conv_in = '0;
    conv_threshold = 8'h02;
    dither_code = 8'h5a;
    slide_constant = 8'ha5;
    // count rising edges so the x-to-0 step of the clock at time zero is not taken for a cycle
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst_n = 1;
    t_regs;
    conv(16'h0000, 13'h001f, 1'b0, 1'b1);
    conv(16'h0000, 13'h0020, 1'b1, 1'b1);
    conv(16'h0100, 13'h0003, 1'b0, 1'b1);
    conv(16'h0100, 13'h0004, 1'b1, 1'b1);
    conv(16'h0010, 13'h0000, 1'b1, 1'b1);
    conv(16'h0000, 13'h1fff, 1'b0, 1'b1);
    conv(16'h0008, 13'h1fff, 1'b1, 1'b1);
    conv(16'h0002, 13'h0fff, 1'b1, 1'b0);
    conv(16'h0040, 13'h0fff, 1'b0, 1'b1);
    conv(16'h0004, 13'h0fff, 1'b0, 1'b0);
    evt(16'h4000, 1'b0, 1'b1, 1'b0);
    evt(16'h0000, 1'b0, 1'b0, 1'b0);
    evt(16'h0000, 1'b1, 1'b1, 1'b0);
    evt(16'h1000, 1'b1, 1'b1, 1'b1);
    t_slide;
    t_flush;
    t_memtest;
    t_syn;
    results;
  end
endmodule
